/* tad_checker.sv */
// Purpose: port checker for the transient detector
// Assumes: register writes shadowed from the port strobes
// Notes: flag raise and drop checked in bypass mode only; flag rise cause checked in every mode
`timescale 1ns/1ns
`default_nettype none
module tad_checker
   import tad_pkg::*;
#(
   parameter int W = 14
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic sample_valid_i,
   input wire logic signed [W-1:0] accel_x_i,
   input wire logic signed [W-1:0] accel_y_i,
   input wire logic signed [W-1:0] accel_z_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic event_flag_o
);
   // ********************
   // write shadows
   // ********************
   logic [7:0] cfg_r;
   logic [7:0] ths_r;
   logic [7:0] cnt_r;
   wire logic rd_src = reg_rd_i && reg_addr_i == TAD_ADDR_SRC;
   wire logic [W-1:0] thr = W'({ths_r[6:0], 6'h00});
   wire logic [W-1:0] mx = accel_x_i[W-1] ? -accel_x_i : accel_x_i;
   wire logic [W-1:0] my = accel_y_i[W-1] ? -accel_y_i : accel_y_i;
   wire logic [W-1:0] mz = accel_z_i[W-1] ? -accel_z_i : accel_z_i;
   wire logic over = cfg_r[1] && mx > thr || cfg_r[2] && my > thr || cfg_r[3] && mz > thr;
   wire logic byp_smp = sample_valid_i && cfg_r[0];
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         cfg_r <= 8'h00;
         ths_r <= 8'h00;
         cnt_r <= 8'h00;
      end else if (reg_wr_i && reg_addr_i == TAD_ADDR_CFG) begin
         cfg_r <= reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == TAD_ADDR_THS) begin
         ths_r <= reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == TAD_ADDR_CNT) begin
         cnt_r <= reg_wdata_i;
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   a_cfg_readback: assert property (reg_rd_i && reg_addr_i == TAD_ADDR_CFG
      |=> reg_rdata_o == {3'h0, cfg_r[4:0]}) else $error("config readback wrong");
   a_thr_readback: assert property (reg_rd_i && reg_addr_i == TAD_ADDR_THS
      |=> reg_rdata_o == ths_r) else $error("threshold readback wrong");
   a_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < 8'h1D || reg_addr_i > 8'h20)
      |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
   a_src_reserved: assert property (rd_src |=> !reg_rdata_o[7])
      else $error("source reserved bit set");
   a_any_event_or: assert property (rd_src
      |=> reg_rdata_o[6] == (reg_rdata_o[5] | reg_rdata_o[3] | reg_rdata_o[1]))
      else $error("any-event not OR of flags");
   a_read_clears: assert property (rd_src && !sample_valid_i && !$past(sample_valid_i)
      ##1 !sample_valid_i && !reg_wr_i ##1 rd_src && !sample_valid_i |=> reg_rdata_o == 8'h00)
      else $error("source read did not clear");
   a_event_raised: assert property (byp_smp && cnt_r <= 8'h01 && over
      |=> event_flag_o) else $error("event not raised");
   a_live_drop: assert property (byp_smp && !cfg_r[4] && !over |=> !event_flag_o)
      else $error("live flag not dropped");
   a_flag_cause: assert property ($rose(event_flag_o)
      |-> $past(sample_valid_i) || $past(sample_valid_i, 2) || $past(reg_wr_i))
      else $error("flag rose without cause");
   c_latched: cover property (rd_src && cfg_r[4]);
   c_filtered: cover property (sample_valid_i && !cfg_r[0] ##2 event_flag_o);
   c_negative: cover property (rd_src ##1 reg_rdata_o[0]);
endmodule : tad_checker
bind transient_accel_detector tad_checker #(.W(W)) u_chk (.sys_clk_i, .reset_n_i,
   .sample_valid_i, .accel_x_i, .accel_y_i, .accel_z_i, .reg_addr_i, .reg_wdata_i,
   .reg_wr_i, .reg_rd_i, .reg_rdata_o, .event_flag_o);
`default_nettype wire

/* tad_host.sv */
// Purpose: host model driving the register port
// Assumes: strobes one cycle, changed at falling edge
// Notes: write data inverted once released
`timescale 1ns/1ns
`default_nettype none
module tad_host (
   input wire logic sys_clk_i,
   input wire logic [7:0] rdata_i,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   initial begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge sys_clk_i);
      wr_o = 1'b0;
      wdata_o = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge sys_clk_i);
      rd_o = 1'b0;
      d = rdata_i;
   endtask : rd
endmodule : tad_host
`default_nettype wire

/* tad_hpf.sv */
// Purpose: first-order high-pass filter on three axes
// Assumes: valid pulses once per sample
// Notes: baseline tracks input with gain 2^-K
`timescale 1ns/1ns
`default_nettype none
module tad_hpf
   import tad_pkg::*;
#(
   parameter int W = 14,
   parameter int K = 4
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   tad_smp_if.hpf s
);
   // ***************************************************
   // per-axis baseline and difference
   // ***************************************************
   logic signed [W+K:0] acc_r [3];
   logic signed [W:0] filt_r [3];
   logic valid_r;
   logic signed [W:0] diff [3];

   for (genvar g = 0; g < 3; g++) begin : g_ax
      assign diff[g] = (W+1)'(s.raw[g]) - (W+1)'(acc_r[g] >>> K);
      assign s.filt[g] = filt_r[g];
   end

   assign s.filt_valid = valid_r;

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         valid_r <= 1'b0;
         for (int i = 0; i < 3; i++) begin
            acc_r[i] <= '0;
            filt_r[i] <= '0;
         end
      end else begin
         valid_r <= s.valid;
         if (s.valid) begin
            for (int i = 0; i < 3; i++) begin
               acc_r[i] <= acc_r[i] + (W+K+1)'(diff[i]);
               filt_r[i] <= diff[i];
            end
         end
      end
   end
endmodule : tad_hpf
`default_nettype wire

/* tad_pkg.sv */
// Purpose: shared constants of the transient acceleration detector
// Assumes: 8-bit register port, signed axis samples
// Notes: offsets, field positions and reset values
package tad_pkg;
   // ***************************************************
   // register offsets
   // ***************************************************
   localparam logic [7:0] TAD_ADDR_CFG = 8'h1D;
   localparam logic [7:0] TAD_ADDR_SRC = 8'h1E;
   localparam logic [7:0] TAD_ADDR_THS = 8'h1F;
   localparam logic [7:0] TAD_ADDR_CNT = 8'h20;
   // ***************************************************
   // configuration fields
   // ***************************************************
   localparam int TAD_CFG_BYP = 0;
   localparam int TAD_CFG_XEFE = 1;
   localparam int TAD_CFG_ELE = 4;
   localparam int TAD_CFG_W = 5;
   // ***************************************************
   // source fields
   // ***************************************************
   localparam int TAD_SRC_POL0 = 0;
   localparam int TAD_SRC_EF0 = 1;
   localparam int TAD_SRC_EA = 6;
   // ***************************************************
   // threshold fields
   // ***************************************************
   localparam int TAD_THS_DBCNTM = 7;
   localparam int TAD_THS_W = 7;
   localparam int TAD_THS_MG = 63;
   // ***************************************************
   // reset values
   // ***************************************************
   localparam logic [7:0] TAD_RST_CFG = 8'h00;
   localparam logic [7:0] TAD_RST_SRC = 8'h00;
   localparam logic [7:0] TAD_RST_THS = 8'h00;
   localparam logic [7:0] TAD_RST_CNT = 8'h00;
endpackage : tad_pkg

/* tad_smp_if.sv */
// Purpose: sample carrier between detector and high-pass filter
// Assumes: one sample strobe per output period
// Notes: filtered values are one bit wider than raw
`timescale 1ns/1ns
`default_nettype none
interface tad_smp_if #(
   parameter int W = 14
);
   logic valid;
   logic signed [W-1:0] raw [3];
   logic filt_valid;
   logic signed [W:0] filt [3];
   modport src (output valid, output raw, input filt_valid, input filt);
   modport hpf (input valid, input raw, output filt_valid, output filt);
endinterface : tad_smp_if
`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench for the transient detector
// Assumes: integer model of filter, debounce and flags
// Notes: random register and sample traffic after directed cases
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) \
   n_checks++; \
   if ((g) !== (e)) begin \
      $display("FAIL %s exp %0h got %0h", nm, e, g); \
      err_total++; \
   end
module tb_top;
   import tad_pkg::*;
   logic sys_clk, reset_n, sv, wr, rd, flag;
   logic signed [13:0] acc [3];
   logic [7:0] addr, wdata, rdata, d;
   int err_total, n_checks, seed, m_cfg, m_ths, m_cnt, m_src, m_deb;
   int base [3];
   transient_accel_detector dut (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
      .sample_valid_i(sv), .accel_x_i(acc[0]), .accel_y_i(acc[1]), .accel_z_i(acc[2]),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .event_flag_o(flag));
   tad_host host (.sys_clk_i(sys_clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd));
   // ********************
   // model and tasks
   // ********************
   function automatic int xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic w(input int a, input int v);
      host.wr(8'(a), 8'(v));
      if (a == TAD_ADDR_CFG) m_cfg = v & 31;
      if (a == TAD_ADDR_THS) m_ths = v & 255;
      if (a == TAD_ADDR_CNT) m_cnt = v & 255;
   endtask : w
   task automatic rs();
      host.rd(TAD_ADDR_SRC, d);
      `CHK("source", m_src, d)
      m_src = 0;
   endtask : rs
   task automatic smp(input int x, input int y, input int z);
      int f [3];
      int c;
      int ev;
      int ov [3];
      int dl;
      f = '{x, y, z};
      c = 0;
      @(negedge sys_clk);
      sv = 1'b1;
      for (int i = 0; i < 3; i++) acc[i] = 14'(f[i]);
      @(negedge sys_clk);
      sv = 1'b0;
      @(negedge sys_clk);
      for (int i = 0; i < 3; i++) begin
         dl = f[i] - (base[i] >>> 4);
         base[i] += dl;
         if (!m_cfg[0]) f[i] = dl;
         ov[i] = m_cfg[i + 1] && (f[i] > (m_ths & 127) * 64 || -f[i] > (m_ths & 127) * 64);
         c |= ov[i];
      end
      if (c) begin
         m_deb = m_deb < 255 ? m_deb + 1 : 255;
         ev = m_deb >= m_cnt;
      end else begin
         m_deb = m_ths[7] ? 0 : (m_deb > 0 ? m_deb - 1 : 0);
         ev = 0;
      end
      if (ev && !(m_cfg[4] && m_src != 0)) begin
         for (int i = 0; i < 3; i++) begin
            if (ov[i]) m_src = (m_src & ~(3 << 2 * i)) | ((2 | (f[i] < 0)) << 2 * i);
         end
         m_src |= 64;
      end
      `CHK("event flag", m_cfg[4] ? m_src != 0 : ev, flag)
   endtask : smp
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      #3000000;
      err_total++;
      report_and_stop();
   end
   initial begin
      seed = 7081;
      sv = 1'b0;
      acc = '{14'h0000, 14'h0000, 14'h0000};
      reset_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      reset_n = 1'b1;
      for (int a = 8'h1C; a <= 8'h21; a++) begin
         host.rd(8'(a), d);
         `CHK("reset or unmapped", 0, d)
      end
      w(TAD_ADDR_THS, 8'h0A);
      w(TAD_ADDR_CFG, 8'h02);
      repeat (32) smp(4000, 5000, 0);
      rs();
      rs();
      w(TAD_ADDR_CFG, 8'hFF);
      host.rd(TAD_ADDR_CFG, d);
      `CHK("config", 8'h1F, d)
      host.wr(TAD_ADDR_SRC, 8'hFF);
      rs();
      repeat (40) begin
         w(TAD_ADDR_CFG, xs() | 1);
         w(TAD_ADDR_THS, xs());
         w(TAD_ADDR_CNT, xs() & 3);
         host.rd(TAD_ADDR_THS, d);
         `CHK("threshold", m_ths, d)
         repeat (8) smp(xs() % 8191, xs() % 8191, xs() % 8191);
         rs();
      end
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire

/* transient_accel_detector.sv */
// Purpose: transient acceleration event detector with register port
// Assumes: samples and register strobes on sys_clk_i
// Notes: read data appears one cycle after the read strobe
//
// Notes on behaviour
// - optional high-pass filter removes DC offset; bypass uses raw data.
// - event when any enabled axis exceeds threshold for the debounce count.
// - latch bit clear: event flag follows detection sample by sample.
// - latch bit set: event flag held until source register is read.
// - per-axis enable bits allow or ignore each axis.
// - bypass bit 0 selects filtered data, 1 selects raw data.
// - config holds three reserved, latch, Z/Y/X enables, bypass; resets zero.
// - source reports enabled axis events and their direction.
// - source holds reserved, any-event, then Z/Y/X flag-polarity pairs; resets zero.
// - polarity 0 above positive, 1 below negative; any-event ORs flags.
// - latched freezes flags at trigger; unlatched updates; read clears.
// - condition false: counter decrements in mode 0, clears in mode 1.
// - threshold 7-bit unsigned at 63 mg per step; count 8-bit periods.
`timescale 1ns/1ns
`default_nettype none
module transient_accel_detector
   import tad_pkg::*;
#(
   parameter int W = 14,
   parameter int HPF_K = 4,
   parameter int CNT_W = 8,
   parameter int SAMPLE_UG_PER_LSB = 976
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic sample_valid_i,
   input wire logic signed [W-1:0] accel_x_i,
   input wire logic signed [W-1:0] accel_y_i,
   input wire logic signed [W-1:0] accel_z_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic event_flag_o
);
   // ***************************************************
   // constants and helpers
   // ***************************************************
   localparam int THS_STEP = (TAD_THS_MG * 1000) / SAMPLE_UG_PER_LSB;

   function automatic logic [W:0] tad_mag(input logic signed [W:0] v);
      tad_mag = v[W] ? (W+1)'(-v) : v;
   endfunction : tad_mag

   function automatic logic [2:0] tad_pick3(input logic [7:0] w, input int lsb);
      tad_pick3 = {w[lsb+4], w[lsb+2], w[lsb]};
   endfunction : tad_pick3

   // ***************************************************
   // registers
   // ***************************************************
   logic [TAD_CFG_W-1:0] cfg_r;
   logic [7:0] ths_r;
   logic [CNT_W-1:0] count_r;
   logic [2:0] flag_r;
   logic [2:0] pol_r;
   logic [CNT_W-1:0] dbc_r;
   logic live_r;
   logic [7:0] rdata_r;

   // ***************************************************
   // sample path
   // ***************************************************
   tad_smp_if #(.W(W)) smp ();

   assign smp.valid = sample_valid_i;
   assign smp.raw[0] = accel_x_i;
   assign smp.raw[1] = accel_y_i;
   assign smp.raw[2] = accel_z_i;

   tad_hpf #(
      .W(W),
      .K(HPF_K)
   ) u_hpf (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .s(smp)
   );

   // ***************************************************
   // control decode
   // ***************************************************
   wire byp = cfg_r[TAD_CFG_BYP];
   wire latch = cfg_r[TAD_CFG_ELE];
   wire [2:0] axis_en = cfg_r[TAD_CFG_XEFE +: 3];
   wire cnt_mode = ths_r[TAD_THS_DBCNTM];
   wire [TAD_THS_W-1:0] ths_val = ths_r[TAD_THS_W-1:0];
   wire [31:0] thr = 32'(ths_val) * 32'(THS_STEP);
   wire det_valid = byp ? sample_valid_i : smp.filt_valid;
   wire sel_cfg = reg_addr_i == TAD_ADDR_CFG;
   wire sel_src = reg_addr_i == TAD_ADDR_SRC;
   wire sel_ths = reg_addr_i == TAD_ADDR_THS;
   wire sel_cnt = reg_addr_i == TAD_ADDR_CNT;
   wire src_rd = reg_rd_i & sel_src;
   wire wr_cfg = reg_wr_i & sel_cfg;
   wire wr_ths = reg_wr_i & sel_ths;
   wire wr_cnt = reg_wr_i & sel_cnt;

   // ***************************************************
   // per-axis comparison
   // ***************************************************
   logic signed [W:0] det_val [3];
   logic [2:0] neg;
   logic [2:0] exceed;
   logic [2:0] base_flag;
   logic [2:0] base_pol;
   logic [2:0] load;
   logic [2:0] flag_nxt;
   logic [2:0] pol_nxt;
   logic trig;
   logic base_any;

   for (genvar g = 0; g < 3; g++) begin : g_axis
      assign det_val[g] = byp ? (W+1)'(smp.raw[g]) : smp.filt[g];
      assign neg[g] = det_val[g][W];
      assign exceed[g] = axis_en[g] & (32'(tad_mag(det_val[g])) > thr);
      assign base_flag[g] = src_rd ? 1'b0 : flag_r[g];
      assign base_pol[g] = src_rd ? 1'b0 : pol_r[g];
      assign load[g] = trig & exceed[g] & (~latch | ~base_any);
      assign flag_nxt[g] = load[g] | base_flag[g];
      assign pol_nxt[g] = load[g] ? neg[g] : base_pol[g];
   end

   // ***************************************************
   // debounce
   // ***************************************************
   wire cond = |exceed;
   wire cnt_full = dbc_r == {CNT_W{1'b1}};
   wire [CNT_W-1:0] cnt_inc = cnt_full ? dbc_r : dbc_r + 1'b1;
   wire [CNT_W-1:0] cnt_dec = (dbc_r == '0) ? dbc_r : dbc_r - 1'b1;
   wire reached = cnt_inc >= count_r;
   assign trig = det_valid & cond & reached;
   assign base_any = |base_flag;
   wire [CNT_W-1:0] dbc_fall = cnt_mode ? '0 : cnt_dec;
   wire [CNT_W-1:0] dbc_nxt = ~det_valid ? dbc_r : (cond ? cnt_inc : dbc_fall);

   // ***************************************************
   // read data
   // ***************************************************
   wire any_event_active = |flag_r;
   wire [7:0] src_word = {1'b0, any_event_active, flag_r[2], pol_r[2],
                          flag_r[1], pol_r[1], flag_r[0], pol_r[0]};
   wire [7:0] cfg_word = {3'h0, cfg_r};
   wire [7:0] rd_mux = sel_cfg ? cfg_word :
                       sel_src ? src_word :
                       sel_ths ? ths_r :
                       sel_cnt ? 8'(count_r) : 8'h00;

   assign reg_rdata_o = rdata_r;
   assign event_flag_o = latch ? any_event_active : live_r;

   // ***************************************************
   // configuration registers
   // ***************************************************
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         cfg_r <= TAD_RST_CFG[TAD_CFG_W-1:0];
      end else if (wr_cfg) begin
         cfg_r <= reg_wdata_i[TAD_CFG_W-1:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         ths_r <= TAD_RST_THS;
      end else if (wr_ths) begin
         ths_r <= reg_wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         count_r <= CNT_W'(TAD_RST_CNT);
      end else if (wr_cnt) begin
         count_r <= CNT_W'(reg_wdata_i);
      end
   end

   // ***************************************************
   // source and detection state
   // ***************************************************
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         flag_r <= tad_pick3(TAD_RST_SRC, TAD_SRC_EF0);
         pol_r <= tad_pick3(TAD_RST_SRC, TAD_SRC_POL0);
      end else begin
         flag_r <= flag_nxt;
         pol_r <= pol_nxt;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         dbc_r <= '0;
      end else begin
         dbc_r <= dbc_nxt;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         live_r <= 1'b0;
      end else if (det_valid) begin
         live_r <= cond & reached;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         rdata_r <= 8'h00;
      end else if (reg_rd_i) begin
         rdata_r <= rd_mux;
      end
   end
endmodule : transient_accel_detector
`default_nettype wire
